// ### logic/lim_monitor.sv
`timescale 1ns/1ps

module lim_monitor #(
	parameter int LVL_W = 5,
	parameter int unsigned TICK = lim_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic off_hook,
	input wire logic dial_start,
	input wire logic data_mode,
	input wire logic connecting,
	input wire logic cmd_call,
	input wire logic security_call,
	input wire logic [1:0] security_mode,
	input wire logic fsk_active,
	input wire logic line_present,
	input wire logic carrier_lost,
	input wire logic carrier_detect,
	input wire logic loop_low,
	input wire logic loop_high,
	input wire logic [LVL_W-1:0] loop_sense_level,
	input wire logic [3:0] settle_time,
	input wire logic [6:0] deglitch_rate,
	input wire logic offhook_detect_select,
	input wire logic [2:0] diff_current_threshold,
	input wire logic abs_thresh_wr,
	input wire logic [4:0] abs_thresh_wdata,
	input wire logic [1:0] block_method,
	input wire logic [7:0] block_time,
	input wire logic [1:0] pin_four_func,
	input wire logic [1:0] pin_two_func,
	input wire logic carrier_pin_aux_select,
	input wire logic carrier_detect_enable,
	input wire logic alert_level_clear,
	input wire logic loop_loss_enable,
	input wire logic [7:0] overcurrent_check_delay,
	output logic [4:0] abs_current_threshold,
	output logic intrusion_flag,
	output logic no_line_flag,
	output logic overcurrent_flag,
	output logic alert_output_level,
	output logic general_pin_four,
	output logic general_pin_two,
	output logic code_valid,
	output logic [7:0] code
);
	lim_pkg::lim_state_t state;
	logic [31:0] tick_cnt;
	logic tick;
	logic [15:0] ms_cnt;
	logic [15:0] phase_ms;
	logic [15:0] period_ms;
	logic [15:0] period_cnt;
	logic sample_now;
	logic [LVL_W-1:0] hist [lim_pkg::HIST_DEPTH];
	logic [2:0] hist_fill;
	logic [LVL_W-1:0] ref_level;
	logic dg_valid;
	logic [LVL_W-1:0] dg_value;
	logic intr;
	logic [LVL_W-1:0] last_clean;
	logic [LVL_W-1:0] pre_block;
	logic post_block_pending;
	logic line_prev;
	logic line_lost;
	logic loop_prev;
	logic oc_done;
	logic carrier_prev;
	logic codes_ok;
	logic diff2;
	logic is_m1;
	logic is_m2;
	logic detect_start;
	logic detect_end;
	logic [LVL_W:0] drop;
	logic [LVL_W:0] rise;
	logic [15:0] settle_ms;
	logic [15:0] block_ms;
	logic phase_restart;

	// Method selection; the absolute method ignores the deglitch rate.
	assign diff2 = offhook_detect_select && deglitch_rate != 7'h00;
	assign is_m1 = offhook_detect_select && deglitch_rate == 7'h00;
	assign is_m2 = diff2;
	assign settle_ms = 16'(settle_time) * 16'(lim_pkg::SETTLE_UNIT_MS);
	assign block_ms = 16'(block_time) * 16'(lim_pkg::BLOCK_UNIT_MS);

	// Intrusion and loop codes allowed only outside data mode and in the permitted call phases.
	assign codes_ok = !data_mode && (connecting || cmd_call || (security_call
		&& (security_mode != lim_pkg::SEC_MODE_FSK || !fsk_active)));

	// ==========================================================
	// Millisecond timebase.
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (rst || tick || state == lim_pkg::LIM_IDLE)
		begin
			tick_cnt <= '0;
		end
		else
		begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end
	assign tick = tick_cnt == 32'(TICK - 1);

	// Blocking and the on-hook hold are timed from their own entry, not from seizure.
	assign phase_restart = (state != lim_pkg::LIM_IDLE && state != lim_pkg::LIM_HOLD
		&& !off_hook) || (state == lim_pkg::LIM_RUN && is_m2 && dial_start
		&& block_method != 2'h0);

	// Milliseconds since seizure, or since entry to blocking or hold; the timebase is restarted in idle.
	always_ff @(posedge ref_clk)
	begin
		if (rst || state == lim_pkg::LIM_IDLE || phase_restart)
		begin
			ms_cnt <= '0;
		end
		else if (tick && ms_cnt != 16'hffff)
		begin
			ms_cnt <= ms_cnt + 16'h1;
		end
	end

	// ==========================================================
	// Comparison period: 200 ms, or 40 ms times the deglitch rate.
	// ==========================================================
	assign period_ms = is_m2 ? 16'(deglitch_rate) * 16'(lim_pkg::METHOD2_PERIOD_MS)
		: 16'(lim_pkg::METHOD1_PERIOD_MS);

	always_ff @(posedge ref_clk)
	begin
		if (rst || state != lim_pkg::LIM_RUN)
		begin
			period_cnt <= '0;
			sample_now <= 1'b0;
		end
		else
		begin
			sample_now <= 1'b0;
			if (tick)
			begin
				if (period_cnt + 16'h1 >= period_ms)
				begin
					period_cnt <= '0;
					sample_now <= 1'b1;
				end
				else
				begin
					period_cnt <= period_cnt + 16'h1;
				end
			end
		end
	end
	assign phase_ms = ms_cnt;

	lim_deglitch #(
		.W(LVL_W)
	) u_deglitch (
		.ref_clk(ref_clk),
		.rst(rst),
		.sample_en(sample_now && is_m2),
		.sample_in(loop_sense_level),
		.valid(dg_valid),
		.value(dg_value)
	);

	// ==========================================================
	// Sample history; the lag is two periods in method two, four in one.
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (rst || state == lim_pkg::LIM_IDLE)
		begin
			hist_fill <= '0;
			for (int i = 0; i < lim_pkg::HIST_DEPTH; i++)
			begin
				hist[i] <= '0;
			end
		end
		else if ((is_m1 && sample_now) || (is_m2 && dg_valid))
		begin
			hist[0] <= is_m2 ? dg_value : loop_sense_level;
			for (int i = 1; i < lim_pkg::HIST_DEPTH; i++)
			begin
				hist[i] <= hist[i-1];
			end
			if (hist_fill != 3'(lim_pkg::HIST_DEPTH))
			begin
				hist_fill <= hist_fill + 3'h1;
			end
		end
	end

	// In method two a preloaded threshold stands in as reference until two samples are held.
	assign ref_level = is_m2 ? ((hist_fill >= 3'h2) ? hist[1]
		: (abs_current_threshold != 5'h00 ? LVL_W'(abs_current_threshold) : hist[0]))
		: hist[lim_pkg::HIST_DEPTH-1];
	assign drop = {1'b0, ref_level} - {1'b0, (is_m2 ? dg_value : loop_sense_level)};
	assign rise = {1'b0, (is_m2 ? dg_value : loop_sense_level)} - {1'b0, ref_level};

	always_comb
	begin
		detect_start = 1'b0;
		detect_end = 1'b0;
		if (state == lim_pkg::LIM_RUN)
		begin
			if (is_m1 && sample_now && hist_fill == 3'(lim_pkg::HIST_DEPTH))
			begin
				detect_start = !drop[LVL_W] && drop > (LVL_W+1)'(diff_current_threshold);
				detect_end = !rise[LVL_W] && rise > (LVL_W+1)'(diff_current_threshold);
			end
			else if (is_m2 && dg_valid && (hist_fill != 3'h0
				|| abs_current_threshold != 5'h00))
			begin
				detect_start = !drop[LVL_W] && drop > (LVL_W+1)'(diff_current_threshold);
				detect_end = !rise[LVL_W] && rise > (LVL_W+1)'(diff_current_threshold);
			end
			else if (!offhook_detect_select)
			begin
				detect_start = LVL_W'(loop_sense_level) < abs_current_threshold;
				detect_end = !(loop_sense_level < abs_current_threshold);
			end
		end
		else if (state == lim_pkg::LIM_BLOCK && post_block_pending && phase_ms >= block_ms)
		begin
			detect_start = pre_block > loop_sense_level
				&& pre_block - loop_sense_level > LVL_W'(diff_current_threshold);
		end
	end

	// ==========================================================
	// Phase machine: settle, run, optional blocking, on-hook hold.
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state <= lim_pkg::LIM_IDLE;
		end
		else
		begin
			unique case (state)
				lim_pkg::LIM_IDLE: if (off_hook) state <= lim_pkg::LIM_SETTLE;
				lim_pkg::LIM_SETTLE:
					if (!off_hook) state <= lim_pkg::LIM_HOLD;
					else if (phase_ms >= settle_ms) state <= lim_pkg::LIM_RUN;
				lim_pkg::LIM_RUN:
					if (!off_hook) state <= lim_pkg::LIM_HOLD;
					else if (is_m2 && dial_start && block_method != 2'h0)
						state <= lim_pkg::LIM_BLOCK;
				lim_pkg::LIM_BLOCK:
					if (!off_hook) state <= lim_pkg::LIM_HOLD;
					else if (block_method != lim_pkg::BLOCK_ABSOLUTE || phase_ms >= block_ms)
						state <= lim_pkg::LIM_RUN;
				lim_pkg::LIM_HOLD:
					if (phase_ms >= 16'(lim_pkg::FLAG_HOLD_MS)) state <= lim_pkg::LIM_IDLE;
			endcase
		end
	end

	// Sample taken just before blocking, compared once BLOCK_ABSOLUTE blocking ends.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pre_block <= '0;
			post_block_pending <= 1'b0;
		end
		else if (state == lim_pkg::LIM_RUN && is_m2 && dial_start)
		begin
			pre_block <= loop_sense_level;
			post_block_pending <= 1'b1;
		end
		else if (state != lim_pkg::LIM_BLOCK)
		begin
			post_block_pending <= 1'b0;
		end
	end

	// ==========================================================
	// Intrusion state, reference keeping and threshold write-back.
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			intr <= 1'b0;
			last_clean <= '0;
			abs_current_threshold <= lim_pkg::ABS_THRESH_RST;
			line_prev <= 1'b0;
			line_lost <= 1'b0;
		end
		else
		begin
			line_prev <= line_present;
			if (state == lim_pkg::LIM_IDLE)
			begin
				intr <= 1'b0;
			end
			else if (detect_start)
			begin
				intr <= 1'b1;
			end
			else if (detect_end)
			begin
				intr <= 1'b0;
			end
			if (!intr && !detect_start && (sample_now || dg_valid))
			begin
				last_clean <= loop_sense_level;
			end
			if (state == lim_pkg::LIM_IDLE && line_prev && !line_present)
			begin
				line_lost <= 1'b1;
			end
			if (abs_thresh_wr)
			begin
				abs_current_threshold <= abs_thresh_wdata;
			end
			else if (state != lim_pkg::LIM_IDLE && state != lim_pkg::LIM_HOLD && !off_hook)
			begin
				abs_current_threshold <= 5'(last_clean);
			end
			else if (state == lim_pkg::LIM_IDLE && line_lost && line_present)
			begin
				abs_current_threshold <= '0;
				line_lost <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Status flags, result codes and the latched event pin.
	// ==========================================================
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			intrusion_flag <= 1'b0;
			no_line_flag <= 1'b0;
			overcurrent_flag <= 1'b0;
			alert_output_level <= 1'b0;
			code_valid <= 1'b0;
			code <= '0;
			loop_prev <= 1'b0;
			oc_done <= 1'b0;
			carrier_prev <= 1'b0;
		end
		else
		begin
			code_valid <= 1'b0;
			loop_prev <= loop_low;
			carrier_prev <= carrier_lost;
			if (state != lim_pkg::LIM_HOLD)
			begin
				intrusion_flag <= intr;
			end
			if (alert_level_clear)
			begin
				alert_output_level <= 1'b0;
			end
			if (state == lim_pkg::LIM_IDLE)
			begin
				oc_done <= 1'b0;
			end
			else if (!oc_done && off_hook && state != lim_pkg::LIM_HOLD
				&& phase_ms >= 16'(overcurrent_check_delay) * 16'(lim_pkg::OC_UNIT_MS))
			begin
				oc_done <= 1'b1;
				if (loop_high)
				begin
					overcurrent_flag <= 1'b1;
					code <= lim_pkg::CODE_OVERCURRENT;
					code_valid <= 1'b1;
				end
			end
			if (detect_start && !intr)
			begin
				alert_output_level <= 1'b1;
				code <= lim_pkg::CODE_INTR_START;
				code_valid <= codes_ok;
			end
			else if (detect_end && intr)
			begin
				code <= lim_pkg::CODE_INTR_END;
				code_valid <= codes_ok;
			end
			else if (loop_loss_enable && off_hook && loop_low && !loop_prev)
			begin
				no_line_flag <= 1'b1;
				code <= lim_pkg::CODE_LOOP_LOSS;
				code_valid <= codes_ok;
			end
			else if (loop_loss_enable && off_hook && !loop_low && loop_prev)
			begin
				no_line_flag <= 1'b0;
				alert_output_level <= 1'b1;
				code <= lim_pkg::CODE_LOOP_BACK;
				code_valid <= codes_ok;
			end
			if (data_mode && carrier_lost && !carrier_prev)
			begin
				alert_output_level <= 1'b1;
			end
		end
	end

	// Pin multiplexing, registered so outputs come from flip-flops.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			general_pin_four <= 1'b0;
			general_pin_two <= 1'b0;
		end
		else
		begin
			general_pin_four <= pin_four_func == lim_pkg::PIN_FUNC_ALERT
				&& alert_output_level;
			general_pin_two <= pin_two_func == lim_pkg::PIN_FUNC_CARRIER
				&& !carrier_pin_aux_select && carrier_detect_enable && carrier_detect;
		end
	end

endmodule // lim_monitor

// ### logic/lim_pkg.sv
package lim_pkg;

	// ==========================================================
	// Timing constants (40 MHz reference clock).
	// ==========================================================
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned METHOD1_PERIOD_MS = 200;
	localparam int unsigned METHOD1_LAG_MS = 800;
	localparam int unsigned METHOD2_PERIOD_MS = 40;
	localparam int unsigned METHOD2_LAG_MS = 80;
	localparam int unsigned SETTLE_UNIT_MS = 250;
	localparam int unsigned FLAG_HOLD_MS = 800;
	localparam int unsigned OC_UNIT_MS = 1;
	localparam int unsigned BLOCK_UNIT_MS = 100;
	localparam int unsigned HIST_DEPTH = METHOD1_LAG_MS / METHOD1_PERIOD_MS;

	// ==========================================================
	// Reset values of programmable fields, and field encodings.
	// ==========================================================
	localparam logic [3:0] SETTLE_TIME_RST = 4'h4;
	localparam logic [2:0] DIFF_THRESH_RST = 3'h2;
	localparam logic [4:0] ABS_THRESH_RST = 5'h00;
	localparam logic [7:0] OC_DELAY_RST = 8'h14;
	localparam logic [1:0] BLOCK_ABSOLUTE = 2'h2;
	localparam logic [1:0] PIN_FUNC_ALERT = 2'h3;
	localparam logic [1:0] PIN_FUNC_CARRIER = 2'h1;
	localparam logic [1:0] SEC_MODE_FSK = 2'h2;

	// ==========================================================
	// Result codes sent to the host.
	// ==========================================================
	localparam logic [7:0] CODE_INTR_START = 8'h69;
	localparam logic [7:0] CODE_INTR_END = 8'h49;
	localparam logic [7:0] CODE_LOOP_LOSS = 8'h6c;
	localparam logic [7:0] CODE_LOOP_BACK = 8'h4c;
	localparam logic [7:0] CODE_OVERCURRENT = 8'h78;

	// Supervisor phases, from idle through seizure to the on-hook hold.
	typedef enum logic [4:0] {
		LIM_IDLE = 5'b00001,
		LIM_SETTLE = 5'b00010,
		LIM_RUN = 5'b00100,
		LIM_BLOCK = 5'b01000,
		LIM_HOLD = 5'b10000
	} lim_state_t;

endpackage

// ### logic/lim_deglitch.sv
`timescale 1ns/1ps

// ==========================================================
// Deglitch stage: a sample is confirmed by the next equal one.
// ==========================================================
module lim_deglitch #(
	parameter int W = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic sample_en,
	input wire logic [W-1:0] sample_in,
	output logic valid,
	output logic [W-1:0] value
);
	logic [W-1:0] prev;
	logic have_prev;

	// A mismatching sample replaces the candidate and nothing is passed on.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			prev <= '0;
			have_prev <= 1'b0;
			valid <= 1'b0;
			value <= '0;
		end
		else
		begin
			valid <= 1'b0;
			if (sample_en)
			begin
				prev <= sample_in;
				have_prev <= 1'b1;
				if (have_prev && sample_in == prev)
				begin
					valid <= 1'b1;
					value <= sample_in;
				end
			end
		end
	end

endmodule // lim_deglitch

// ### sim/lim_chk_monitor.sv
`timescale 1ns/1ps

// ==========================================
// Port checker for the line supervisor.
module lim_chk #(
	parameter int unsigned TICK = lim_pkg::TICK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic off_hook,
	input wire logic data_mode,
	input wire logic connecting,
	input wire logic cmd_call,
	input wire logic security_call,
	input wire logic [1:0] security_mode,
	input wire logic fsk_active,
	input wire logic line_present,
	input wire logic carrier_detect,
	input wire logic [3:0] settle_time,
	input wire logic abs_thresh_wr,
	input wire logic [4:0] abs_thresh_wdata,
	input wire logic [1:0] pin_four_func,
	input wire logic [1:0] pin_two_func,
	input wire logic carrier_pin_aux_select,
	input wire logic carrier_detect_enable,
	input wire logic alert_level_clear,
	input wire logic [7:0] overcurrent_check_delay,
	input wire logic [4:0] abs_current_threshold,
	input wire logic overcurrent_flag,
	input wire logic alert_output_level,
	input wire logic general_pin_four,
	input wire logic general_pin_two,
	input wire logic code_valid,
	input wire logic [7:0] code
);
	int unsigned hook_cnt;

	// Cycles since the line was seized; timing rules are judged against it.
	always_ff @(posedge ref_clk)
	begin
		if (rst || !off_hook)
			hook_cnt <= 0;
		else
			hook_cnt <= hook_cnt + 1;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_intr_code;
		code_valid && (code == lim_pkg::CODE_INTR_START || code == lim_pkg::CODE_INTR_END);
	endsequence
	sequence s_alert_held;
		alert_output_level && !alert_level_clear;
	endsequence

	chk_settle_quiet: assert property (s_intr_code |->
		hook_cnt >= int'(settle_time) * lim_pkg::SETTLE_UNIT_MS * TICK)
		else $error("intrusion code during settling");
	chk_data_quiet: assert property (s_intr_code |-> !$past(data_mode))
		else $error("intrusion code in data mode");
	chk_call_phase: assert property (s_intr_code |-> $past(connecting || cmd_call
		|| (security_call && (security_mode != lim_pkg::SEC_MODE_FSK || !fsk_active))))
		else $error("intrusion code outside allowed phase");
	chk_alert_latch: assert property (s_alert_held |=> alert_output_level)
		else $error("alert dropped without clear");
	chk_pin_four: assert property ($past(pin_four_func) == lim_pkg::PIN_FUNC_ALERT
		|-> general_pin_four == $past(alert_output_level))
		else $error("pin four does not follow alert");
	chk_carrier_pin: assert property ($past(pin_two_func == lim_pkg::PIN_FUNC_CARRIER
		&& !carrier_pin_aux_select && carrier_detect_enable)
		|-> general_pin_two == $past(carrier_detect))
		else $error("pin two does not follow carrier");
	chk_oc_delay: assert property ($rose(overcurrent_flag)
		|-> hook_cnt >= int'(overcurrent_check_delay) * TICK)
		else $error("overcurrent flagged before delay");
	chk_oc_sticky: assert property (overcurrent_flag |=> overcurrent_flag)
		else $error("overcurrent flag dropped");
	chk_thresh_write: assert property (abs_thresh_wr && !off_hook && line_present
		|=> abs_current_threshold == $past(abs_thresh_wdata))
		else $error("threshold write lost");
endmodule // lim_chk

bind lim_monitor lim_chk #(.TICK(TICK)) u_chk (.ref_clk, .rst, .off_hook, .data_mode,
	.connecting, .cmd_call, .security_call, .security_mode, .fsk_active, .line_present,
	.carrier_detect, .settle_time, .abs_thresh_wr, .abs_thresh_wdata, .pin_four_func,
	.pin_two_func, .carrier_pin_aux_select, .carrier_detect_enable, .alert_level_clear,
	.overcurrent_check_delay, .abs_current_threshold, .overcurrent_flag, .alert_output_level,
	.general_pin_four, .general_pin_two, .code_valid, .code);

// ### sim/lim_host_model.sv
`timescale 1ns/1ps

// ==========================================
// Host processor model: services the alert and preloads the threshold.
module lim_host_model #(
	parameter int SERVICE = 50
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic alert_output_level,
	input wire logic auto_clear,
	input wire logic method_two,
	output logic alert_level_clear,
	output logic abs_thresh_wr,
	output logic [4:0] abs_thresh_wdata,
	output logic [6:0] deglitch_rate
);
	int wait_cnt = 0;

	initial
	begin
		alert_level_clear = 1'b0;
		abs_thresh_wr = 1'b0;
		abs_thresh_wdata = 5'h00;
	end

	// One-second deglitch interval when the filtered method is wanted.
	assign deglitch_rate = method_two ? 7'h19 : 7'h00;

	// The host is slow on purpose, so the latch must hold until it acts.
	always @(negedge ref_clk)
	begin
		if (rst || !alert_output_level || !auto_clear)
		begin
			wait_cnt <= 0;
			alert_level_clear <= 1'b0;
		end
		else
		begin
			wait_cnt <= wait_cnt + 1;
			alert_level_clear <= (wait_cnt == SERVICE);
		end
	end

	// Loads a known undisturbed reading before the line is seized.
	task automatic preload(input logic [4:0] v);
		@(negedge ref_clk);
		abs_thresh_wdata = v;
		abs_thresh_wr = 1'b1;
		@(negedge ref_clk);
		abs_thresh_wr = 1'b0;
	endtask
endmodule // lim_host_model

// ### sim/line_intrusion_monitor_tb.sv
`timescale 1ns/1ps

// ==========================================
// Bench for the line supervisor, with a shortened millisecond tick.
module line_intrusion_monitor_tb;
	localparam int unsigned TICK = 4;
	typedef struct {logic [1:0] func; logic aux; logic en; logic cd; logic pin;} lim_row_t;
	lim_row_t rows [5] = '{'{2'h1, 0, 1, 1, 1}, '{2'h1, 0, 1, 0, 0}, '{2'h1, 1, 1, 1, 0},
		'{2'h1, 0, 0, 1, 0}, '{2'h0, 0, 1, 1, 0}};
	logic ref_clk = 0, rst = 1, off_hook = 0, dial_start = 0, data_mode = 0, connecting = 1;
	logic cmd_call = 0, security_call = 0, fsk_active = 0, line_present = 1, carrier_lost = 0;
	logic carrier_detect = 0, loop_low = 0, loop_high = 0, offhook_detect_select = 1;
	logic carrier_pin_aux_select = 0, carrier_detect_enable = 1, loop_loss_enable = 0;
	logic auto_clear = 0, method_two = 0;
	logic [1:0] security_mode = 2'h0, block_method = 2'h0, pin_four_func = 2'h3;
	logic [1:0] pin_two_func = 2'h1;
	logic [4:0] loop_sense_level = 5'h14;
	logic [3:0] settle_time = 4'h4;
	logic [2:0] diff_current_threshold = 3'h2;
	logic [7:0] block_time = 8'h0a, overcurrent_check_delay = 8'h14;
	logic [6:0] deglitch_rate;
	logic abs_thresh_wr, alert_level_clear, intrusion_flag, no_line_flag, overcurrent_flag;
	logic alert_output_level, general_pin_four, general_pin_two, code_valid;
	logic [4:0] abs_thresh_wdata, abs_current_threshold;
	logic [7:0] code;
	int mismatches = 0;
	int n_compared = 0;

	// Free-running 40 MHz clock.
	always #12.5 ref_clk = ~ref_clk;

	lim_monitor #(.LVL_W(5), .TICK(TICK)) dut (.ref_clk, .rst, .off_hook, .dial_start,
		.data_mode, .connecting, .cmd_call, .security_call, .security_mode, .fsk_active,
		.line_present, .carrier_lost, .carrier_detect, .loop_low, .loop_high,
		.loop_sense_level, .settle_time, .deglitch_rate, .offhook_detect_select,
		.diff_current_threshold, .abs_thresh_wr, .abs_thresh_wdata, .block_method,
		.block_time, .pin_four_func, .pin_two_func, .carrier_pin_aux_select,
		.carrier_detect_enable, .alert_level_clear, .loop_loss_enable,
		.overcurrent_check_delay, .abs_current_threshold, .intrusion_flag, .no_line_flag,
		.overcurrent_flag, .alert_output_level, .general_pin_four, .general_pin_two,
		.code_valid, .code);

	lim_host_model #(.SERVICE(50)) host (.ref_clk, .rst, .alert_output_level, .auto_clear,
		.method_two, .alert_level_clear, .abs_thresh_wr, .abs_thresh_wdata, .deglitch_rate);

	// ==========================================
	// Shared helpers.
	task automatic complete_run();
		if (mismatches == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Bounded wait for a level; a lapse counts as a mismatch and ends the run.
	task automatic wait_lvl(input string what, ref logic sig, input logic val, input int lim);
		for (int i = 0; i < lim && sig !== val; i++)
			@(negedge ref_clk);
		check(what, {7'h00, val}, {7'h00, sig});
		if (sig !== val)
			complete_run();
	endtask

	// Codes are one-cycle pulses, so each negedge is looked at.
	task automatic wait_code(input logic [7:0] exp, input int lim);
		for (int i = 0; i < lim && code_valid !== 1'b1; i++)
			@(negedge ref_clk);
		check("code", exp, code);
		if (code_valid !== 1'b1)
			complete_run();
		@(negedge ref_clk);
	endtask

	// ==========================================
	// Main sequence.
	initial
	begin
		cyc(6);
		rst = 0;
		check("after reset", 8'h00, {abs_current_threshold, intrusion_flag, overcurrent_flag, code_valid});
		foreach (rows[i])
		begin
			{pin_two_func, carrier_pin_aux_select, carrier_detect_enable, carrier_detect} =
				{rows[i].func, rows[i].aux, rows[i].en, rows[i].cd};
			cyc(2);
			check("pin two", {7'h00, rows[i].pin}, {7'h00, general_pin_two});
		end
		// Method one: a drop larger than the threshold, then recovery.
		off_hook = 1;
		dial_start = 1;
		cyc(1);
		dial_start = 0;
		cyc(2000 * TICK);
		loop_sense_level = 5'h10;
		wait_code(lim_pkg::CODE_INTR_START, 400 * TICK);
		check("intrusion", 8'h01, {7'h00, intrusion_flag});
		cyc(1000 * TICK);
		check("alert held", 8'h01, {7'h00, alert_output_level});
		loop_sense_level = 5'h14;
		wait_code(lim_pkg::CODE_INTR_END, 400 * TICK);
		auto_clear = 1;
		wait_lvl("alert clear", alert_output_level, 0, 200);
		// Data mode: carrier loss first, then an intrusion that raises the alert and the intrusion flag but sends no code.
		connecting = 0;
		data_mode = 1;
		carrier_lost = 1;
		wait_lvl("carrier alert", alert_output_level, 1, 400 * TICK);
		check("loss cause", 8'h00, {7'h00, intrusion_flag});
		carrier_lost = 0;
		wait_lvl("alert clear", alert_output_level, 0, 200);
		loop_sense_level = 5'h0c;
		wait_lvl("data alert", alert_output_level, 1, 400 * TICK);
		cyc(2);
		check("pin four", 8'h01, {7'h00, general_pin_four});
		check("intrusion", 8'h01, {7'h00, intrusion_flag});
		// Hang up: flag is held and the last clean sample is stored.
		off_hook = 0;
		cyc(600 * TICK);
		check("held flag", 8'h01, {7'h00, intrusion_flag});
		check("stored ref", 8'h14, {3'h0, abs_current_threshold});
		cyc(400 * TICK);
		line_present = 0;
		cyc(10);
		line_present = 1;
		cyc(10);
		check("reconnect", 8'h00, {3'h0, abs_current_threshold});
		// Absolute method from command mode, with an overcurrent at seizure.
		data_mode = 0;
		cmd_call = 1;
		offhook_detect_select = 0;
		loop_high = 1;
		host.preload(5'h12);
		cyc(2);
		check("preload", 8'h12, {3'h0, abs_current_threshold});
		off_hook = 1;
		cyc(15 * TICK);
		check("early oc", 8'h00, {7'h00, overcurrent_flag});
		wait_lvl("overcurrent", overcurrent_flag, 1, 10 * TICK);
		wait_code(lim_pkg::CODE_OVERCURRENT, 4);
		loop_high = 0;
		cyc(1200 * TICK);
		loop_sense_level = 5'h0f;
		wait_code(lim_pkg::CODE_INTR_START, 400 * TICK);
		loop_sense_level = 5'h14;
		wait_code(lim_pkg::CODE_INTR_END, 400 * TICK);
		// Loop current loss in security mode two with no FSK traffic.
		cmd_call = 0;
		security_call = 1;
		security_mode = 2'h2;
		loop_loss_enable = 1;
		loop_low = 1;
		wait_code(lim_pkg::CODE_LOOP_LOSS, 400 * TICK);
		check("no line", 8'h01, {7'h00, no_line_flag});
		loop_low = 0;
		wait_code(lim_pkg::CODE_LOOP_BACK, 400 * TICK);
		check("line back", 8'h00, {7'h00, no_line_flag});
		// Method two with a preloaded reference: the line is already disturbed at seizure.
		off_hook = 0;
		cyc(1000 * TICK);
		offhook_detect_select = 1;
		method_two = 1;
		loop_sense_level = 5'h0c;
		host.preload(5'h14);
		off_hook = 1;
		wait_code(lim_pkg::CODE_INTR_START, 4000 * TICK);
		check("m2 intrusion", 8'h01, {7'h00, intrusion_flag});
		off_hook = 0;
		cyc(10);
		complete_run();
	end
endmodule // line_intrusion_monitor_tb
